/* File: inc/ifd_consts.vh */
// Purpose: constants for the instruction format and timing decoder
// Assumes: 24-bit program words, 8-bit opcode field in the top bits
// Notes:   opcode values are a plain coding chosen for this decoder
`ifndef IFD_CONSTS_VH
`define IFD_CONSTS_VH
`define IFD_WORD_W       24
`define IFD_OPC_W        8
`define IFD_OPC_MSB      23
`define IFD_OPC_LSB      16
// Operand field positions
`define IFD_BASE_MSB     14
`define IFD_BASE_LSB     11
`define IFD_DST_MSB      10
`define IFD_DST_LSB      7
`define IFD_DMODE_MSB    6
`define IFD_DMODE_LSB    4
`define IFD_SRC_MSB      3
`define IFD_SRC_LSB      0
`define IFD_SMODE_MSB    15
`define IFD_SMODE_LSB    15
`define IFD_FILE_MSB     12
`define IFD_FILE_LSB     0
`define IFD_FDIR_BIT     13
`define IFD_BIT_MSB      15
`define IFD_BIT_LSB      12
`define IFD_BITIND_BIT   11
`define IFD_LIT_MSB      15
`define IFD_LIT_LSB      0
`define IFD_TBLMODE_MSB  1
`define IFD_TBLMODE_LSB  0
// Program address: low 16 bits in the first word, high 7 bits in the second
`define IFD_ADRLO_MSB    15
`define IFD_ADRLO_LSB    0
`define IFD_ADRHI_MSB    6
`define IFD_ADRHI_LSB    0
// Opcode codes (classes in upper nibble)
`define IFD_OPC_NOP2     8'h00
`define IFD_CLS_ACCUMULATOR_REG     4'h1
`define IFD_CLS_FILE     4'h2
`define IFD_CLS_BIT      4'h3
`define IFD_CLS_LITMOV   4'h4
`define IFD_CLS_LITALU   4'h5
`define IFD_CLS_CTRL     4'h6
`define IFD_CLS_SKIP     4'h7
`define IFD_OPC_JMP      8'h60
`define IFD_OPC_CJMP     8'h61
`define IFD_OPC_ICALL    8'h62
`define IFD_OPC_TBLRD    8'h63
`define IFD_OPC_TBLWR    8'h64
`define IFD_OPC_RET      8'h65
`define IFD_OPC_IEXIT    8'h66
`define IFD_OPC_CBR      8'h67
`define IFD_OPC_AJMP2    8'h68
`define IFD_OPC_CALL2    8'h69
`define IFD_OPC_MOVD2    8'h6A
// Cycle counts
`define IFD_CYC_1        2'd1
`define IFD_CYC_2        2'd2
`define IFD_CYC_3        2'd3
// Class codes on the output
`define IFD_K_NONE       3'd0
`define IFD_K_ACCUMULATOR_REG       3'd1
`define IFD_K_FILE       3'd2
`define IFD_K_BIT        3'd3
`define IFD_K_LITMOV     3'd4
`define IFD_K_LITALU     3'd5
`define IFD_K_CTRL       3'd6
`endif

/* File: design/ifd_word_pair.v */
// Purpose: holds the first word of a two-word instruction
// Assumes: one word offered per load strobe
// Notes:   read data leave from a register
`timescale 1ns/100ps
`include "ifd_consts.vh"
module ifd_word_pair
#(
    parameter WIDTH = 24
)
(
    input  wire             ref_clk,
    input  wire             reset_n,
    input  wire             load,
    input  wire [WIDTH-1:0] wrData,
    output reg  [WIDTH-1:0] rdData_ff
);
    // Latch the held word; cleared so a stray read shows zero
    always @(posedge ref_clk)
    begin
        if (!reset_n)
            rdData_ff <= {WIDTH{1'b0}};
        else if (load)
            rdData_ff <= wrData;
    end
endmodule

/* File: design/ifd_decoder.v */
// Purpose: decodes instruction words into opcode, operands and cycles
// Assumes: words arrive from program memory on ref_clk with a valid
//          strobe; skipNextTwo and condTrue come from core logic
// Notes:   a decoded result stands one cycle after the word is taken
// How it works
// (RQ1) 24-bit word, 8-bit opcode field, operands
// (RQ2) Two-word instructions join into 48 bits
// (RQ3) Lone second word, top zero, is NOP
// (RQ4) One cycle; two if true or jumping
// (RQ5) Branches, tables, returns take two/three cycles
// (RQ6) Skip costs two or three cycles
// (RQ7) Two-word and double moves take two cycles
// (RQ8) Register ops decode base, source, destination
// (RQ9) File ops: location, dest same or zero
// (RQ10) Bit ops: operand plus literal/register bit
// (RQ11) Literal moves load value into target
// (RQ12) Literal ALU: base, literal, optional dest
// (RQ13) Control ops: address or table mode
`timescale 1ns/100ps
`include "ifd_consts.vh"
module ifd_decoder
(
    input  wire        ref_clk,
    input  wire        reset_n,
    input  wire        wordValid,
    input  wire [23:0] wordData,
    input  wire        condTrue,
    input  wire        skipNextTwo,
    output reg         decValid_ff,
    output reg  [7:0]  opcode_ff,
    output reg  [2:0]  instClass_ff,
    output reg  [3:0]  baseOperandReg_ff,
    output reg  [3:0]  secondSourceReg_ff,
    output reg         srcModEn_ff,
    output reg  [3:0]  resultDestReg_ff,
    output reg  [2:0]  destMode_ff,
    output reg  [12:0] fileAddr_ff,
    output reg         destIsWorkingZero_ff,
    output reg  [3:0]  bitPos_ff,
    output reg         bitFromBaseReg_ff,
    output reg  [15:0] literal_ff,
    output reg         destSameAsBase_ff,
    output reg  [22:0] progAddr_ff,
    output reg  [1:0]  tableMode_ff,
    output reg         isNop_ff,
    output reg         twoWord_ff,
    output reg  [1:0]  cycles_ff
);
    // One-hot states: waiting for a first word or for a second word
    localparam [1:0] ST_FIRST  = 2'b01;
    localparam [1:0] ST_SECOND = 2'b10;

    reg  [1:0]  state_ff;
    reg  [1:0]  nxt_state;
    wire [23:0] heldWord;
    wire [7:0]  opc = wordData[`IFD_OPC_MSB:`IFD_OPC_LSB];
    wire [3:0]  cls = opc[7:4];
    reg         needsSecond;
    reg  [1:0]  nxt_cycles;
    reg  [2:0]  nxt_class;

    // (RQ2) first word held
    ifd_word_pair #(.WIDTH(`IFD_WORD_W)) uHold
    (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .load      (wordValid && state_ff[0] && needsSecond),
        .wrData    (wordData),
        .rdData_ff (heldWord)
    );

    // Class, two-word detection and cycle count for a first word
    always @*
    begin
        needsSecond = 1'b0;
        nxt_cycles  = `IFD_CYC_1;
        nxt_class   = `IFD_K_NONE;
        // (RQ1) opcode picks class
        case (cls)
            `IFD_CLS_ACCUMULATOR_REG:   nxt_class = `IFD_K_ACCUMULATOR_REG;
            `IFD_CLS_FILE:   nxt_class = `IFD_K_FILE;
            `IFD_CLS_BIT:    nxt_class = `IFD_K_BIT;
            `IFD_CLS_LITMOV: nxt_class = `IFD_K_LITMOV;
            `IFD_CLS_LITALU: nxt_class = `IFD_K_LITALU;
            `IFD_CLS_CTRL:   nxt_class = `IFD_K_CTRL;
            `IFD_CLS_SKIP:   nxt_class = `IFD_K_CTRL;
            default:         nxt_class = `IFD_K_NONE;
        endcase
        // (RQ4) taken condition adds cycle
        if (cls == `IFD_CLS_CTRL && opc == `IFD_OPC_CBR && condTrue)
            nxt_cycles = `IFD_CYC_2;
        // (RQ6) skip by skipped size
        if (cls == `IFD_CLS_SKIP && condTrue)
            nxt_cycles = skipNextTwo ? `IFD_CYC_3 : `IFD_CYC_2;
        case (opc)
            // (RQ5) flow change, tables, returns
            `IFD_OPC_JMP, `IFD_OPC_CJMP, `IFD_OPC_ICALL,
            `IFD_OPC_TBLRD, `IFD_OPC_TBLWR:
                nxt_cycles = `IFD_CYC_2;
            // Returns also refill the pipeline from the stack
            `IFD_OPC_RET, `IFD_OPC_IEXIT:
                nxt_cycles = `IFD_CYC_3;
            // (RQ7) two-word, two cycles
            `IFD_OPC_AJMP2, `IFD_OPC_CALL2, `IFD_OPC_MOVD2:
            begin
                needsSecond = 1'b1;
                nxt_cycles  = `IFD_CYC_2;
            end
            default:
                nxt_cycles = nxt_cycles;
        endcase
    end

    // State: a two-word opcode waits for its partner word
    always @*
    begin
        case (state_ff)
            ST_FIRST:
                nxt_state = (wordValid && needsSecond) ? ST_SECOND
                                                       : ST_FIRST;
            ST_SECOND:
                nxt_state = wordValid ? ST_FIRST : ST_SECOND;
            default:
                nxt_state = ST_FIRST;
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (!reset_n)
            state_ff <= ST_FIRST;
        else
            state_ff <= nxt_state;
    end

    // Output fields; decValid pulses once per whole instruction
    always @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            decValid_ff          <= 1'b0;
            opcode_ff            <= 8'h00;
            instClass_ff         <= `IFD_K_NONE;
            baseOperandReg_ff    <= 4'h0;
            secondSourceReg_ff   <= 4'h0;
            srcModEn_ff          <= 1'b0;
            resultDestReg_ff     <= 4'h0;
            destMode_ff          <= 3'h0;
            fileAddr_ff          <= 13'h0000;
            destIsWorkingZero_ff <= 1'b0;
            bitPos_ff            <= 4'h0;
            bitFromBaseReg_ff    <= 1'b0;
            literal_ff           <= 16'h0000;
            destSameAsBase_ff    <= 1'b0;
            progAddr_ff          <= 23'h00_0000;
            tableMode_ff         <= 2'h0;
            isNop_ff             <= 1'b0;
            twoWord_ff           <= 1'b0;
            cycles_ff            <= `IFD_CYC_1;
        end
        else if (wordValid && state_ff[1])
        begin
            // (RQ2) join 48-bit instruction
            decValid_ff  <= 1'b1;
            opcode_ff    <= heldWord[`IFD_OPC_MSB:`IFD_OPC_LSB];
            instClass_ff <= `IFD_K_CTRL;
            twoWord_ff   <= 1'b1;
            isNop_ff     <= 1'b0;
            cycles_ff    <= `IFD_CYC_2;
            // (RQ13) address spans both words
            progAddr_ff  <= {wordData[`IFD_ADRHI_MSB:`IFD_ADRHI_LSB],
                             heldWord[`IFD_ADRLO_MSB:`IFD_ADRLO_LSB]};
            literal_ff   <= heldWord[15:0];
        end
        else if (wordValid && !needsSecond)
        begin
            decValid_ff  <= 1'b1;
            opcode_ff    <= opc;
            twoWord_ff   <= 1'b0;
            // (RQ3) lone second word NOP
            isNop_ff     <= (opc == `IFD_OPC_NOP2);
            instClass_ff <= nxt_class;
            cycles_ff    <= nxt_cycles;
            // (RQ8) three register operands
            baseOperandReg_ff  <= wordData[`IFD_BASE_MSB:`IFD_BASE_LSB];
            secondSourceReg_ff <= wordData[`IFD_SRC_MSB:`IFD_SRC_LSB];
            srcModEn_ff        <= wordData[`IFD_SMODE_MSB];
            resultDestReg_ff   <= wordData[`IFD_DST_MSB:`IFD_DST_LSB];
            destMode_ff        <= wordData[`IFD_DMODE_MSB:`IFD_DMODE_LSB];
            // (RQ9) file location and direction
            fileAddr_ff          <= wordData[`IFD_FILE_MSB:`IFD_FILE_LSB];
            destIsWorkingZero_ff <= (cls == `IFD_CLS_FILE)
                                    && wordData[`IFD_FDIR_BIT];
            // (RQ10) bit position source
            bitPos_ff         <= wordData[`IFD_BIT_MSB:`IFD_BIT_LSB];
            bitFromBaseReg_ff <= (cls == `IFD_CLS_BIT)
                                 && wordData[`IFD_BITIND_BIT];
            // (RQ11) immediate for moves
            literal_ff <= wordData[`IFD_LIT_MSB:`IFD_LIT_LSB];
            // (RQ12) dest only when different
            destSameAsBase_ff <= (cls == `IFD_CLS_LITALU)
                && (wordData[`IFD_DMODE_MSB:`IFD_DMODE_LSB] == 3'h7);
            // (RQ13) table mode field
            tableMode_ff <= wordData[`IFD_TBLMODE_MSB:`IFD_TBLMODE_LSB];
            progAddr_ff  <= {7'h00,
                             wordData[`IFD_ADRLO_MSB:`IFD_ADRLO_LSB]};
        end
        else
            decValid_ff <= 1'b0;
    end
endmodule

/* File: tb/ifd_decoder_monitor.sv */
// Purpose: port checks for the decoder
// Assumes: one clock, sync active-low reset
// Notes:   a result follows its last word by one edge
`timescale 1ns/100ps
module ifd_decoder_monitor
(
    input logic        ref_clk,
    input logic        reset_n,
    input logic        wordValid,
    input logic [23:0] wordData,
    input logic        condTrue,
    input logic        skipNextTwo,
    input logic        decValid_ff,
    input logic [7:0]  opcode_ff,
    input logic [2:0]  instClass_ff,
    input logic [3:0]  baseOperandReg_ff,
    input logic [3:0]  secondSourceReg_ff,
    input logic        destIsWorkingZero_ff,
    input logic [22:0] progAddr_ff,
    input logic        isNop_ff,
    input logic        twoWord_ff,
    input logic [1:0]  cycles_ff
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    logic [15:0] firstLow = 16'h0000;

    // Keep the opener's low address; the partner word may come late
    always @(posedge ref_clk)
        if (wordValid && wordData[23:16] inside {8'h68, 8'h69, 8'h6A})
            firstLow <= wordData[15:0];

    opc_field_a: assert property (decValid_ff && !twoWord_ff
        |-> opcode_ff == $past(wordData[23:16])) else $error("bad opcode");
    pair_addr_a: assert property (decValid_ff && twoWord_ff
        |-> progAddr_ff == {$past(wordData[6:0]), firstLow})
        else $error("bad address");
    nop_word_a: assert property (decValid_ff && opcode_ff == 8'h00
        |-> isNop_ff && cycles_ff == 2'h1) else $error("bad no-op");
    branch_cyc_a: assert property (decValid_ff && opcode_ff inside
        {[8'h60:8'h64]} |-> cycles_ff == 2'h2) else $error("bad branch");
    return_cyc_a: assert property (decValid_ff && opcode_ff inside
        {8'h65, 8'h66} |-> cycles_ff == 2'h3) else $error("bad return");
    skip_cyc_a: assert property (decValid_ff && opcode_ff[7:4] == 4'h7
        |-> cycles_ff == ($past(condTrue) ? ($past(skipNextTwo) ? 2'h3
        : 2'h2) : 2'h1)) else $error("bad skip");
    two_cyc_a: assert property (decValid_ff && twoWord_ff
        |-> cycles_ff == 2'h2) else $error("bad two-word");
    accumulator_reg_ops_a: assert property (decValid_ff && instClass_ff == 3'h1
        |-> {baseOperandReg_ff, secondSourceReg_ff} == {$past(wordData[14:11]),
        $past(wordData[3:0])}) else $error("bad operands");
    file_dest_a: assert property (decValid_ff && instClass_ff == 3'h2
        |-> destIsWorkingZero_ff == $past(wordData[13])) else $error("bad dest");

    // Main scenarios reached
    cover property (decValid_ff && twoWord_ff);
    cover property (decValid_ff && cycles_ff == 2'h3);
    cover property (decValid_ff && isNop_ff);
endmodule

/* File: tb/ifd_prog_mem.sv */
// Purpose: program memory model feeding words
// Assumes: bench asks for one word per cycle
// Notes:   idle bus shows the inverted last word
`timescale 1ns/100ps
module ifd_prog_mem
(
    input  logic        ref_clk,
    input  logic        fetch,
    input  logic [23:0] fetchWord,
    output logic        wordValid,
    output logic [23:0] wordData
);
    logic [23:0] lastWord_ff = 24'h00_0000;

    // Remember the word so idle cycles never repeat it
    always @(posedge ref_clk)
        if (fetch)
            lastWord_ff <= fetchWord;

    // A stale copy on the bus could pass for a fresh word
    assign wordValid = fetch;
    assign wordData  = fetch ? fetchWord : ~lastWord_ff;
endmodule

/* File: tb/ifd_decoder_tb.sv */
// Purpose: self-checking bench for the decoder
// Assumes: one word per cycle, result one edge later
// Notes:   random words mixed with two-word and lone cases
`timescale 1ns/100ps
module ifd_decoder_tb;
    logic        ref_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic        fetch = 1'b0;
    logic [23:0] fetchWord = 24'h00_0000;
    logic        condTrue = 1'b0;
    logic        skipNextTwo = 1'b0;
    logic        wordValid, decValid_ff, destIsWorkingZero_ff, c, s;
    logic        bitFromBaseReg_ff, destSameAsBase_ff, isNop_ff, twoWord_ff;
    logic [23:0] wordData, w;
    logic [7:0]  opcode_ff;
    logic [2:0]  instClass_ff;
    logic [3:0]  baseOperandReg_ff, secondSourceReg_ff, bitPos_ff;
    logic [12:0] fileAddr_ff;
    logic [15:0] literal_ff;
    logic [22:0] progAddr_ff;
    logic [1:0]  tableMode_ff, cycles_ff;
    logic        srcModEn_ff;
    logic [3:0]  resultDestReg_ff;
    logic [2:0]  destMode_ff;
    int          nMismatch = 0;
    int          testsRun = 0;
    int          cycleCnt = 0;

    ifd_prog_mem u_mem
    (
        .ref_clk   (ref_clk),
        .fetch     (fetch),
        .fetchWord (fetchWord),
        .wordValid (wordValid),
        .wordData  (wordData)
    );

    ifd_decoder u_dut
    (
        .ref_clk              (ref_clk),
        .reset_n              (reset_n),
        .wordValid            (wordValid),
        .wordData             (wordData),
        .condTrue             (condTrue),
        .skipNextTwo          (skipNextTwo),
        .decValid_ff          (decValid_ff),
        .opcode_ff            (opcode_ff),
        .instClass_ff         (instClass_ff),
        .baseOperandReg_ff    (baseOperandReg_ff),
        .secondSourceReg_ff   (secondSourceReg_ff),
        .srcModEn_ff          (srcModEn_ff),
        .resultDestReg_ff     (resultDestReg_ff),
        .destMode_ff          (destMode_ff),
        .fileAddr_ff          (fileAddr_ff),
        .destIsWorkingZero_ff (destIsWorkingZero_ff),
        .bitPos_ff            (bitPos_ff),
        .bitFromBaseReg_ff    (bitFromBaseReg_ff),
        .literal_ff           (literal_ff),
        .destSameAsBase_ff    (destSameAsBase_ff),
        .progAddr_ff          (progAddr_ff),
        .tableMode_ff         (tableMode_ff),
        .isNop_ff             (isNop_ff),
        .twoWord_ff           (twoWord_ff),
        .cycles_ff            (cycles_ff)
    );

    always #20 ref_clk = ~ref_clk;

    task automatic stopTest;
        if (nMismatch == 0 && testsRun > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Exact compare so an unknown never matches
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            nMismatch++;
            $display("MISMATCH %0t %h %h", $time, seen, exp);
        end
    endtask

    // Offer a word after the edge; the next edge takes it
    task automatic put(input logic [23:0] wd);
        fetch = 1'b1;
        fetchWord = wd;
        condTrue = c;
        skipNextTwo = s;
        @(posedge ref_clk);
        #1;
    endtask

    // Cycle cost of a word
    function automatic logic [1:0] expCyc(logic [7:0] o);
        if (o[7:4] == 4'h7)
            return c ? (s ? 2'h3 : 2'h2) : 2'h1;
        if (o inside {[8'h60:8'h64]})
            return 2'h2;
        if (o inside {8'h65, 8'h66})
            return 2'h3;
        return (o == 8'h67 && c) ? 2'h2 : 2'h1;
    endfunction

    task automatic chkWord;
        chk({decValid_ff, opcode_ff}, {1'b1, w[23:16]});
        chk(cycles_ff, expCyc(w[23:16]));
        if (w[23:20] inside {[4'h1:4'h6]})
            chk(instClass_ff, w[22:20]);
        case (w[23:20])
            4'h1: chk({baseOperandReg_ff, secondSourceReg_ff, srcModEn_ff,
                resultDestReg_ff, destMode_ff},
                {w[14:11], w[3:0], w[15], w[10:7], w[6:4]});
            4'h2: chk({destIsWorkingZero_ff, fileAddr_ff}, w[13:0]);
            4'h3: chk({bitFromBaseReg_ff, bitPos_ff},
                {w[11], w[15:12]});
            4'h4: chk(literal_ff, w[15:0]);
            4'h5: chk({destSameAsBase_ff, literal_ff},
                {w[6:4] == 3'h7, w[15:0]});
            4'h6: if (w[23:16] inside {8'h63, 8'h64})
                chk(tableMode_ff, w[1:0]);
        endcase
    endtask

    // Bound the run; it needs under 200 cycles
    always @(posedge ref_clk)
    begin
        cycleCnt++;
        if (cycleCnt == 1000)
        begin
            nMismatch++;
            stopTest;
        end
    end

    initial
    begin
        void'($urandom(32'h551f));
        repeat (2) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        // Back-to-back random words over every class
        for (int i = 0; i < 60; i++)
        begin
            {c, s, w} = $urandom;
            w[23:20] = 4'h1 + $urandom % 7;
            if (w[23:20] == 4'h6)
                w[19:16] = $urandom % 8;
            put(w);
            chkWord;
        end
        // control codes 60-67 and skip codes 78-7F, all condition mixes
        for (int j = 0; j < 16; j++)
        begin
            {c, s} = j[1:0];
            w = 24'($urandom % 65536);
            w[23:16] = (j < 8) ? 8'h60 + j : 8'h70 + j;
            put(w);
            chkWord;
        end
        // first word alone gives nothing; pair joins
        for (int k = 0; k < 3; k++)
        begin
            w = $urandom;
            put({8'h68 + k[7:0], w[15:0]});
            chk(decValid_ff, 1'b0);
            put({17'h0_0000, w[22:16]});
            chk({decValid_ff, twoWord_ff, cycles_ff}, 4'he);
            chk(progAddr_ff, w[22:0]);
        end
        // stray second word with conditions set
        {c, s} = 2'h3;
        put(24'h00_0055);
        chk({decValid_ff, isNop_ff, cycles_ff}, 4'hd);
        fetch = 1'b0;
        @(posedge ref_clk);
        #1;
        chk(decValid_ff, 1'b0);
        // Reset in mid-pair must drop the waiting opener word
        put(24'h68_1234);
        fetch = 1'b0;
        reset_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        chk({decValid_ff, twoWord_ff, opcode_ff, cycles_ff}, 12'h001);
        reset_n = 1'b1;
        {c, s} = 2'h0;
        put(24'h00_0000);
        chk({decValid_ff, isNop_ff, twoWord_ff, cycles_ff}, 5'h19);
        stopTest;
    end
endmodule

bind ifd_decoder ifd_decoder_monitor u_mon
(
    .ref_clk              (ref_clk),
    .reset_n              (reset_n),
    .wordValid            (wordValid),
    .wordData             (wordData),
    .condTrue             (condTrue),
    .skipNextTwo          (skipNextTwo),
    .decValid_ff          (decValid_ff),
    .opcode_ff            (opcode_ff),
    .instClass_ff         (instClass_ff),
    .baseOperandReg_ff    (baseOperandReg_ff),
    .secondSourceReg_ff   (secondSourceReg_ff),
    .destIsWorkingZero_ff (destIsWorkingZero_ff),
    .progAddr_ff          (progAddr_ff),
    .isNop_ff             (isNop_ff),
    .twoWord_ff           (twoWord_ff),
    .cycles_ff            (cycles_ff)
);
